/* io_domain_supply_monitor.sv */
`timescale 1ns/1ps
`include "io_dom_consts.svh"
module io_domain_supply_monitor import io_dom_pkg::*; #(
	parameter int NUM_DOMAINS     = 2,
	parameter int PINS_PER_DOMAIN = 2
) (
	input  wire logic                                   pclk,
	input  wire logic                                   presetn,
	input  wire logic                                   psel,
	input  wire logic                                   penable,
	input  wire logic                                   pwrite,
	input  wire logic [15:0]                            paddr,
	input  wire logic [31:0]                            pwdata,
	output logic      [31:0]                            prdata,
	output logic                                        pready,
	output logic                                        pslverr,
	input  wire logic [NUM_DOMAINS-1:0]                 core_sees_dom_ok,
	input  wire logic [NUM_DOMAINS-1:0]                 dom_sees_core_ok,
	input  wire logic [NUM_DOMAINS-1:0]                 dom_por_n,
	input  wire logic [NUM_DOMAINS-1:0]                 lv_buf_up,
	input  wire logic [5:0]                             adc_chan_sel,
	output logic      [NUM_DOMAINS-1:0]                 vdiv_en,
	output logic      [NUM_DOMAINS-1:0]                 pad_reset,
	output logic      [NUM_DOMAINS-1:0]                 lv_monitor_en,
	output logic      [NUM_DOMAINS-1:0]                 domain_ready,
	output logic      [NUM_DOMAINS-1:0]                 dma_trig,
	output logic                                        irq,
	output logic      [3*NUM_DOMAINS-1:0]               system_input_buffer_select,
	output logic      [3*NUM_DOMAINS-1:0]               i3c_side_input_buffer_select,
	input  wire logic [NUM_DOMAINS*PINS_PER_DOMAIN-1:0] pad_in,
	input  wire logic [NUM_DOMAINS*PINS_PER_DOMAIN-1:0] port_out,
	input  wire logic [NUM_DOMAINS*PINS_PER_DOMAIN-1:0] port_oe,
	input  wire logic [NUM_DOMAINS*PINS_PER_DOMAIN-1:0] i2c_out,
	input  wire logic [NUM_DOMAINS*PINS_PER_DOMAIN-1:0] i2c_oe,
	input  wire logic [NUM_DOMAINS*PINS_PER_DOMAIN-1:0] i3c_out,
	input  wire logic [NUM_DOMAINS*PINS_PER_DOMAIN-1:0] i3c_oe,
	output logic      [NUM_DOMAINS*PINS_PER_DOMAIN-1:0] pad_out,
	output logic      [NUM_DOMAINS*PINS_PER_DOMAIN-1:0] pad_oe,
	output logic      [NUM_DOMAINS*PINS_PER_DOMAIN-1:0] drv_std_en,
	output logic      [NUM_DOMAINS*PINS_PER_DOMAIN-1:0] drv_i3c_en,
	output logic      [NUM_DOMAINS*PINS_PER_DOMAIN-1:0] drv_lv_en,
	output logic      [NUM_DOMAINS*PINS_PER_DOMAIN-1:0] slew_ctrl,
	output logic      [NUM_DOMAINS*PINS_PER_DOMAIN-1:0] sys_in,
	output logic      [NUM_DOMAINS*PINS_PER_DOMAIN-1:0] i3c_in
);
	localparam int N  = NUM_DOMAINS;
	localparam int P  = PINS_PER_DOMAIN;
	localparam int NP = N * P;
	localparam logic [31:0] CTRL_RST_W = `CTRL_RST;

	// Feature bytes fill one 32-bit word, so four domains at most
	if (N < 1 || N > 4 || P < 1) begin : g_bad_params
		$error("io_domain_supply_monitor: one to four domains, one pin at least");
	end

	function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] idx);
		reg_hit = (addr == {idx[13:0], 2'b00});
	endfunction

	// Control and status state
	apb_state_t       apb_q, apb_d;
	logic [31:0]      prdata_d;
	logic             pslverr_d;
	logic [N-1:0]     range_lv_q, range_lv_d;
	logic [N-1:0]     irq_en_q, irq_en_d;
	logic [N-1:0]     flag_q, flag_d;
	logic [N-1:0]     ready_q, ready_d;
	logic [N-1:0]     dma_d, vdiv_d, lvmon_d;
	logic             irq_d;
	logic [8*N-1:0]   feat_q, feat_d;
	logic [3*N-1:0]   system_input_buffer_select_d, i3c_side_input_buffer_select_d;
	logic [N-1:0]     supply_raw, supply_sync;
	logic             wr_fire, rd_fire, any_hit;

	// Cross-coupled monitors and domain reset all must agree
	assign supply_raw = core_sees_dom_ok & dom_sees_core_ok & dom_por_n;

	// Ready lines are asynchronous to pclk
	ready_sync #(
		.WIDTH  (N),
		.STAGES (`SYNC_STAGES)
	) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (supply_raw),
		.q     (supply_sync)
	);

	assign wr_fire = psel && penable && pready && pwrite;
	assign rd_fire = psel && penable && !pready;
	assign any_hit = reg_hit(paddr, `STATUS_IDX) || reg_hit(paddr, `CTRL_IDX)
		|| reg_hit(paddr, `FLAG_IDX) || reg_hit(paddr, `FEAT_IDX);

	// One wait state: read data captured in first access cycle
	always_comb begin
		apb_d = apb_q;
		prdata_d = prdata;
		pslverr_d = 1'b0;
		case (apb_q)
			APB_IDLE: begin
				if (rd_fire) begin
					apb_d = APB_ACK;
					pslverr_d = !any_hit;
					prdata_d = '0;
					if (!pwrite) begin
						if (reg_hit(paddr, `STATUS_IDX))
							prdata_d[N-1:0] = ready_q;
						else if (reg_hit(paddr, `CTRL_IDX)) begin
							prdata_d[`CTRL_RANGE_LSB +: N] = range_lv_q;
							prdata_d[`CTRL_IRQEN_LSB +: N] = irq_en_q;
						end else if (reg_hit(paddr, `FLAG_IDX))
							prdata_d[N-1:0] = flag_q;
						else if (reg_hit(paddr, `FEAT_IDX))
							prdata_d[8*N-1:0] = feat_q;
					end
				end
			end
			APB_ACK: apb_d = APB_IDLE;
			default: apb_d = APB_IDLE;
		endcase
	end

	// Register file and domain state
	always_comb begin
		range_lv_d = range_lv_q;
		irq_en_d = irq_en_q;
		feat_d = feat_q;
		flag_d = flag_q;
		if (wr_fire && reg_hit(paddr, `CTRL_IDX)) begin
			range_lv_d = pwdata[`CTRL_RANGE_LSB +: N];
			irq_en_d = pwdata[`CTRL_IRQEN_LSB +: N];
		end
		if (wr_fire && reg_hit(paddr, `FEAT_IDX))
			feat_d = pwdata[8*N-1:0];
		// Status is read-only; writes to it are dropped
		// Low range reads ready regardless of supply
		ready_d = range_lv_q | supply_sync;
		// Clear by writing one; a change in the same cycle still sets
		if (wr_fire && reg_hit(paddr, `FLAG_IDX))
			flag_d = flag_d & ~pwdata[N-1:0];
		flag_d = flag_d | (ready_d ^ ready_q);
		irq_d = |(flag_q & irq_en_q);
		dma_d = flag_q;
		lvmon_d = range_lv_q;
		for (int d = 0; d < N; d++) begin
			system_input_buffer_select_d[3*d +: 3] = feat_q[8*d + `FEAT_SYSTEM_INPUT_BUFFER_SELECT_LSB +: 3];
			i3c_side_input_buffer_select_d[3*d +: 3] = feat_q[8*d + `FEAT_I3C_SIDE_INPUT_BUFFER_SELECT_LSB +: 3];
			vdiv_d[d] = (adc_chan_sel == 6'(`ADC_CH_BASE + d));
		end
	end

	// No sleep or halt gating: domain logic runs on the free clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_q <= APB_IDLE;
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			range_lv_q <= CTRL_RST_W[`CTRL_RANGE_LSB +: N];
			irq_en_q <= CTRL_RST_W[`CTRL_IRQEN_LSB +: N];
			feat_q <= {N{`FEAT_DOM_RST}};
			flag_q <= '0;
			ready_q <= {N{`READY_RST}};
			irq <= 1'b0;
			dma_trig <= '0;
			vdiv_en <= '0;
			pad_reset <= '0;
			lv_monitor_en <= '0;
			domain_ready <= '0;
			system_input_buffer_select <= {N{3'(`FEAT_DOM_RST)}};
			i3c_side_input_buffer_select <= {N{3'(`FEAT_DOM_RST >> `FEAT_I3C_SIDE_INPUT_BUFFER_SELECT_LSB)}};
		end else begin
			apb_q <= apb_d;
			prdata <= prdata_d;
			pready <= (apb_d == APB_ACK);
			pslverr <= pslverr_d;
			range_lv_q <= range_lv_d;
			irq_en_q <= irq_en_d;
			feat_q <= feat_d;
			flag_q <= flag_d;
			ready_q <= ready_d;
			irq <= irq_d;
			dma_trig <= dma_d;
			vdiv_en <= vdiv_d;
			pad_reset <= lvmon_d;
			lv_monitor_en <= lvmon_d;
			domain_ready <= ready_d;
			system_input_buffer_select <= system_input_buffer_select_d;
			i3c_side_input_buffer_select <= i3c_side_input_buffer_select_d;
		end
	end

	// Each domain's pads run independently of the others
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_dom
			pad_path #(
				.PINS (P)
			) u_pad (
				.clk        (pclk),
				.rst_n      (presetn),
				.ready      (ready_q[g]),
				.range_lv   (range_lv_q[g]),
				.slew_bit   (feat_q[8*g + `FEAT_SLEW_BIT]),
				.sda_delay  (feat_q[8*g + `FEAT_DELAY_BIT]),
				.i3c_buf    (feat_q[8*g + `FEAT_I3C_SIDE_INPUT_BUFFER_SELECT_LSB +: 3]),
				.lv_buf_up  (lv_buf_up[g]),
				.pad_in     (pad_in[g*P +: P]),
				.port_out   (port_out[g*P +: P]),
				.port_oe    (port_oe[g*P +: P]),
				.i2c_out    (i2c_out[g*P +: P]),
				.i2c_oe     (i2c_oe[g*P +: P]),
				.i3c_out    (i3c_out[g*P +: P]),
				.i3c_oe     (i3c_oe[g*P +: P]),
				.pad_out    (pad_out[g*P +: P]),
				.pad_oe     (pad_oe[g*P +: P]),
				.drv_std_en (drv_std_en[g*P +: P]),
				.drv_i3c_en (drv_i3c_en[g*P +: P]),
				.drv_lv_en  (drv_lv_en[g*P +: P]),
				.slew_ctrl  (slew_ctrl[g*P +: P]),
				.sys_in     (sys_in[g*P +: P]),
				.i3c_in     (i3c_in[g*P +: P])
			);
		end
	endgenerate

	// Helper: per-pin view of domain ready and range
	logic [NP-1:0] rdy_pins, lv_pins, lvgate_pins;
	always_comb begin
		for (int i = 0; i < NP; i++) begin
			rdy_pins[i] = ready_q[i / P];
			lv_pins[i] = range_lv_q[i / P];
			lvgate_pins[i] = (feat_q[8*(i / P) + `FEAT_I3C_SIDE_INPUT_BUFFER_SELECT_LSB +: 3] == BUF_I3C_LV) && !lv_buf_up[i / P];
		end
	end

	property p_flag_on_change;
		@(posedge pclk) disable iff (!presetn)
		1 |=> ((ready_q ^ $past(ready_q)) & ~flag_q) == '0;
	endproperty
	a_flag_on_change: assert property (p_flag_on_change) else $error("ready change without flag");

	property p_flag_needs_change;
		@(posedge pclk) disable iff (!presetn)
		1 |=> (flag_q & ~$past(flag_q) & ~(ready_q ^ $past(ready_q))) == '0;
	endproperty
	a_flag_needs_change: assert property (p_flag_needs_change) else $error("flag set with no change");

	property p_irq_follows;
		@(posedge pclk) disable iff (!presetn)
		(|(flag_q & irq_en_q)) |=> irq ##0 (irq || $fell(|flag_q)) [*1];
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("irq missing for enabled flag");

	property p_no_irq_unenabled;
		@(posedge pclk) disable iff (!presetn)
		((flag_q & irq_en_q) == '0) |=> !irq;
	endproperty
	a_no_irq_unenabled: assert property (p_no_irq_unenabled) else $error("irq without enabled flag");

	property p_dma_ignores_enable;
		@(posedge pclk) disable iff (!presetn)
		(flag_q != '0 && irq_en_q == '0) |=> dma_trig == $past(flag_q);
	endproperty
	a_dma_ignores_enable: assert property (p_dma_ignores_enable) else $error("dma trigger lost");

	property p_lv_ready_high;
		@(posedge pclk) disable iff (!presetn)
		1 |=> ($past(range_lv_q) & ~ready_q) == '0;
	endproperty
	a_lv_ready_high: assert property (p_lv_ready_high) else $error("low range ready not high");

	property p_tristate_not_ready;
		@(posedge pclk) disable iff (!presetn)
		1 |=> (pad_oe & ~$past(rdy_pins)) == '0;
	endproperty
	a_tristate_not_ready: assert property (p_tristate_not_ready) else $error("pad driven while not ready");

	property p_slew_i2c_only;
		@(posedge pclk) disable iff (!presetn)
		1 |=> (slew_ctrl & ~$past(i2c_oe & ~i3c_oe)) == '0;
	endproperty
	a_slew_i2c_only: assert property (p_slew_i2c_only) else $error("slew active without i2c drive");

	property p_std_not_low;
		@(posedge pclk) disable iff (!presetn)
		1 |=> (drv_std_en & $past(lv_pins)) == '0;
	endproperty
	a_std_not_low: assert property (p_std_not_low) else $error("standard driver in low range");

	property p_i3c_drv_source;
		@(posedge pclk) disable iff (!presetn)
		1 |=> (drv_i3c_en & ~$past(i3c_oe)) == '0;
	endproperty
	a_i3c_drv_source: assert property (p_i3c_drv_source) else $error("i3c driver without i3c drive");

	property p_status_read;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready && !pwrite && reg_hit(paddr, `STATUS_IDX))
			|-> prdata[N-1:0] == $past(ready_q) && prdata[31:N] == '0;
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read mismatch");

	property p_dma_follows_flag;
		@(posedge pclk) disable iff (!presetn)
		1 |=> dma_trig == $past(flag_q);
	endproperty
	a_dma_follows_flag: assert property (p_dma_follows_flag) else $error("dma trigger not a copy of flag");

	property p_pad_reset_lv;
		@(posedge pclk) disable iff (!presetn)
		1 |=> pad_reset == $past(range_lv_q);
	endproperty
	a_pad_reset_lv: assert property (p_pad_reset_lv) else $error("pad reset not following low range");

	property p_lv_drv_low_only;
		@(posedge pclk) disable iff (!presetn)
		1 |=> (drv_lv_en & ~$past(lv_pins)) == '0;
	endproperty
	a_lv_drv_low_only: assert property (p_lv_drv_low_only) else $error("low driver in standard range");

	property p_std_ready_follows;
		@(posedge pclk) disable iff (!presetn)
		1 |=> (~$past(range_lv_q) & (ready_q ^ $past(supply_sync))) == '0;
	endproperty
	a_std_ready_follows: assert property (p_std_ready_follows) else $error("standard ready not supply");

	property p_lv_buf_gate;
		@(posedge pclk) disable iff (!presetn)
		1 |=> (i3c_in & $past(lvgate_pins)) == '0;
	endproperty
	a_lv_buf_gate: assert property (p_lv_buf_gate) else $error("i3c input not held low in startup");

	property p_vdiv_sel;
		@(posedge pclk) disable iff (!presetn)
		(adc_chan_sel == `ADC_CH_BASE) |=> vdiv_en[0];
	endproperty
	a_vdiv_sel: assert property (p_vdiv_sel) else $error("divided supply tap not enabled");

	property p_sys_in_tristate;
		@(posedge pclk) disable iff (!presetn)
		1 |=> (sys_in & ~$past(rdy_pins)) == '0;
	endproperty
	a_sys_in_tristate: assert property (p_sys_in_tristate) else $error("input seen while not ready");

	c_ready_rise: cover property (@(posedge pclk) disable iff (!presetn) $rose(ready_q[0]) ##1 flag_q[0]);
	c_ready_fall_irq: cover property (@(posedge pclk) disable iff (!presetn) $fell(ready_q[0]) ##[1:4] irq);
	c_flag_clear: cover property (@(posedge pclk) disable iff (!presetn) flag_q[0] ##1 !flag_q[0]);
	c_low_range: cover property (@(posedge pclk) disable iff (!presetn) $rose(range_lv_q[1]) ##1 ready_q[1]);
	c_dma_masked: cover property (@(posedge pclk) disable iff (!presetn) dma_trig[0] && !irq_en_q[0]);
endmodule

/* io_dom_consts.svh */
`ifndef IO_DOM_CONSTS_SVH
`define IO_DOM_CONSTS_SVH

// Register indices; byte address is four times the index
`define STATUS_IDX      16'h04A6
`define CTRL_IDX        16'h04A7
`define FLAG_IDX        16'h04A8
`define FEAT_IDX        16'h04A9

// Control register fields
`define CTRL_RANGE_LSB  0
`define CTRL_IRQEN_LSB  8

// Feature register fields, one byte per domain
`define FEAT_DOM_W      8
`define FEAT_SYSTEM_INPUT_BUFFER_SELECT_LSB 0
`define FEAT_I3C_SIDE_INPUT_BUFFER_SELECT_LSB 3
`define FEAT_SLEW_BIT   6
`define FEAT_DELAY_BIT  7

// Reset values
`define CTRL_RST        32'h0000_0000
`define FEAT_DOM_RST    8'h09
`define READY_RST       1'b0

// Converter channel of the first domain's divided supply
`define ADC_CH_BASE     6'h3C

// Timing
`define SYNC_STAGES     2

`endif

/* io_dom_pkg.sv */
package io_dom_pkg;

	typedef enum logic [2:0] {
		BUF_LV     = 3'h0,
		BUF_ST     = 3'h1,
		BUF_I2C    = 3'h2,
		BUF_SMB2   = 3'h3,
		BUF_SMB3   = 3'h4,
		BUF_I3C_FS = 3'h5,
		BUF_I3C_LV = 3'h6
	} buf_sel_t;

	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_PORT,
		SRC_I2C,
		SRC_I3C
	} drv_src_t;

	typedef enum logic {
		APB_IDLE,
		APB_ACK
	} apb_state_t;

endpackage

/* ready_sync.sv */
`timescale 1ns/1ps
module ready_sync #(
	parameter int WIDTH  = 2,
	parameter int STAGES = 2
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] stage_q [STAGES];
	logic [WIDTH-1:0] stage_d [STAGES];

	if (STAGES < 2 || WIDTH < 1) begin : g_bad_params
		$error("ready_sync: needs two stages and one bit");
	end

	// First stage feeds only the next stage
	always_comb begin
		stage_d[0] = d;
		for (int i = 1; i < STAGES; i++)
			stage_d[i] = stage_q[i-1];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < STAGES; i++)
				stage_q[i] <= '0;
		end else begin
			for (int i = 0; i < STAGES; i++)
				stage_q[i] <= stage_d[i];
		end
	end

	assign q = stage_q[STAGES-1];
endmodule

/* pad_path.sv */
`timescale 1ns/1ps
module pad_path import io_dom_pkg::*; #(
	parameter int PINS = 2
) (
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic            ready,
	input  wire logic            range_lv,
	input  wire logic            slew_bit,
	input  wire logic            sda_delay,
	input  wire logic [2:0]      i3c_buf,
	input  wire logic            lv_buf_up,
	input  wire logic [PINS-1:0] pad_in,
	input  wire logic [PINS-1:0] port_out,
	input  wire logic [PINS-1:0] port_oe,
	input  wire logic [PINS-1:0] i2c_out,
	input  wire logic [PINS-1:0] i2c_oe,
	input  wire logic [PINS-1:0] i3c_out,
	input  wire logic [PINS-1:0] i3c_oe,
	output logic      [PINS-1:0] pad_out,
	output logic      [PINS-1:0] pad_oe,
	output logic      [PINS-1:0] drv_std_en,
	output logic      [PINS-1:0] drv_i3c_en,
	output logic      [PINS-1:0] drv_lv_en,
	output logic      [PINS-1:0] slew_ctrl,
	output logic      [PINS-1:0] sys_in,
	output logic      [PINS-1:0] i3c_in
);
	logic [PINS-1:0] out_d, oe_d, std_d, i3d_d, lvd_d, slew_d, sys_d, i3in_d;
	drv_src_t src;
	logic i3c_gate;

	always_comb begin
		out_d = '0;
		oe_d = '0;
		std_d = '0;
		i3d_d = '0;
		lvd_d = '0;
		slew_d = '0;
		src = SRC_NONE;
		// LV buffer output held low until its startup completes
		i3c_gate = (i3c_buf == BUF_I3C_LV) ? lv_buf_up : 1'b1;
		for (int p = 0; p < PINS; p++) begin
			// I3C wins a clash; distinct addresses are software's job
			if (i3c_oe[p])
				src = SRC_I3C;
			else if (i2c_oe[p])
				src = SRC_I2C;
			else if (port_oe[p] && !range_lv)
				src = SRC_PORT;
			else
				src = SRC_NONE;
			if (ready && src != SRC_NONE) begin
				oe_d[p] = 1'b1;
				case (src)
					SRC_I3C: out_d[p] = i3c_out[p];
					SRC_I2C: out_d[p] = i2c_out[p];
					SRC_PORT: out_d[p] = port_out[p];
					default: out_d[p] = 1'b0;
				endcase
				if (src == SRC_I3C && !sda_delay)
					i3d_d[p] = 1'b1;
				else if (range_lv)
					lvd_d[p] = 1'b1;
				else
					std_d[p] = 1'b1;
				slew_d[p] = slew_bit && src == SRC_I2C && !range_lv;
			end
		end
		sys_d = ready ? pad_in : '0;
		i3in_d = (ready && i3c_gate) ? pad_in : '0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_out <= '0;
			pad_oe <= '0;
			drv_std_en <= '0;
			drv_i3c_en <= '0;
			drv_lv_en <= '0;
			slew_ctrl <= '0;
			sys_in <= '0;
			i3c_in <= '0;
		end else begin
			pad_out <= out_d;
			pad_oe <= oe_d;
			drv_std_en <= std_d;
			drv_i3c_en <= i3d_d;
			drv_lv_en <= lvd_d;
			slew_ctrl <= slew_d;
			sys_in <= sys_d;
			i3c_in <= i3in_d;
		end
	end
endmodule

/* bus_device_model.sv */
`timescale 1ns/1ps
module bus_device_model (
	input  wire logic [3:0] pad_out,
	input  wire logic [3:0] pad_oe,
	input  wire logic [3:0] hold_low,
	output logic      [3:0] pad_in
);
	// Pull-up on every line: a released line goes high unless hold_low pulls it down, never keeps a stale value
	always_comb begin
		pad_in = ~hold_low & (~pad_oe | pad_out);
	end
endmodule

/* io_domain_supply_monitor_tb.sv */
`timescale 1ns/1ps
`include "io_dom_consts.svh"
module io_domain_supply_monitor_tb;
	import io_dom_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic        pready, pslverr, irq, err;
	logic [1:0]  core_sees_dom_ok = 0, dom_sees_core_ok = 0, dom_por_n = 0, lv_buf_up = 0;
	logic [1:0]  vdiv_en, pad_reset, lv_monitor_en, domain_ready, dma_trig;
	logic [5:0]  adc_chan_sel = 6'h00, system_input_buffer_select, i3c_side_input_buffer_select;
	logic [3:0]  port_out = 0, port_oe = 0, i2c_out = 0, i2c_oe = 0, i3c_out = 0, i3c_oe = 0, hold_low = 0;
	logic [3:0]  pad_in, pad_out, pad_oe, drv_std_en, drv_i3c_en, drv_lv_en, slew_ctrl, sys_in, i3c_in;
	int          errors = 0, compares = 0, cyc_n = 0;
	localparam logic [15:0] ST = `STATUS_IDX << 2, CT = `CTRL_IDX << 2;
	localparam logic [15:0] FL = `FLAG_IDX << 2, FT = `FEAT_IDX << 2;

	io_domain_supply_monitor DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .core_sees_dom_ok, .dom_sees_core_ok, .dom_por_n, .lv_buf_up, .adc_chan_sel,
		.vdiv_en, .pad_reset, .lv_monitor_en, .domain_ready, .dma_trig, .irq, .system_input_buffer_select,
		.i3c_side_input_buffer_select, .pad_in, .port_out, .port_oe, .i2c_out, .i2c_oe, .i3c_out, .i3c_oe,
		.pad_out, .pad_oe, .drv_std_en, .drv_i3c_en, .drv_lv_en, .slew_ctrl, .sys_in, .i3c_in);
	bus_device_model partner (.pad_out, .pad_oe, .hold_low, .pad_in);

	initial begin
		forever #2.5 pclk = ~pclk;
	end

	task final_report;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Hang guard well above the 150 or so cycles the sequence needs
	always @(posedge pclk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 5000) begin
			errors++;
			final_report;
		end
	end

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s exp %h seen %h", name, exp, seen);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// Request held until the edge that samples pready high
	task apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task t_regs;
		apb(0, ST, 0); chk("status", rd, 32'h0000_0000);
		apb(0, CT, 0); chk("ctrl", rd, `CTRL_RST);
		apb(0, FT, 0); chk("feat", rd, 32'h0000_0909);
		chk("system_input_buffer_select", system_input_buffer_select, 6'h09);
		apb(0, 16'h1300, 0); chk("unmapped err", err, 1'b1);
		chk("unmapped data", rd, 32'h0000_0000);
		apb(1, ST, 32'h0000_0003); apb(0, ST, 0); chk("status ro", rd, 32'h0000_0000);
	endtask

	task t_supply;
		dom_por_n <= 2'h1; cyc(1); dom_sees_core_ok <= 2'h1; cyc(5);
		chk("ready gated", domain_ready, 2'h0);
		core_sees_dom_ok <= 2'h1; cyc(5);
		chk("ready up", domain_ready, 2'h1);
		chk("dma trig", dma_trig, 2'h1);
		chk("irq masked", irq, 1'b0);
		apb(1, CT, 32'h0000_0100); cyc(3); chk("irq on", irq, 1'b1);
		apb(1, FL, 32'h0000_0001); cyc(3); chk("irq clr", irq, 1'b0);
		apb(0, FL, 0); chk("flag once", rd, 32'h0000_0000);
		core_sees_dom_ok <= 2'h0; cyc(5);
		chk("ready down", domain_ready, 2'h0);
		chk("irq fall", irq, 1'b1);
		core_sees_dom_ok <= 2'h1; cyc(5);
		apb(1, FL, 32'h0000_0003); apb(1, CT, 32'h0000_0000);
	endtask

	task t_pads;
		apb(1, FT, 32'h0000_0949);
		i2c_oe <= 4'hF; i2c_out <= 4'h5; cyc(3);
		chk("oe tristate", pad_oe, 4'h3);
		chk("i2c out", pad_out[1:0], 2'h1);
		chk("std drv", drv_std_en, 4'h3);
		chk("slew i2c", slew_ctrl, 4'h3);
		i2c_oe <= 4'h0; i3c_oe <= 4'h3; i3c_out <= 4'h2; cyc(3);
		chk("i3c out", pad_out[1:0], 2'h2);
		chk("i3c drv", drv_i3c_en, 4'h3);
		chk("slew i3c", slew_ctrl, 4'h0);
		i3c_oe <= 4'h0; cyc(1); apb(1, FT, 32'h0000_09C9); i3c_oe <= 4'h3; cyc(3);
		chk("delayed i3c", drv_std_en, 4'h3);
		i3c_oe <= 4'h0; port_oe <= 4'hF; port_out <= 4'hA; cyc(3);
		chk("port drv", drv_std_en, 4'h3);
		chk("slew port", slew_ctrl, 4'h0);
		chk("port out", pad_out[1:0], 2'h2);
		port_oe <= 4'h0; hold_low <= 4'h1; cyc(3);
		chk("sys in", sys_in, 4'h2);
		hold_low <= 4'h0;
	endtask

	task t_low;
		apb(1, CT, 32'h0000_0002); cyc(5);
		chk("lv ready", domain_ready, 2'h3);
		chk("pad reset", pad_reset, 2'h2);
		chk("lv mon", lv_monitor_en, 2'h2);
		apb(0, ST, 0); chk("status lv", rd, 32'h0000_0003);
		apb(0, FL, 0); chk("flag lv", rd, 32'h0000_0002);
		i2c_oe <= 4'hC; i2c_out <= 4'h0; cyc(3);
		chk("lv drv", drv_lv_en, 4'hC);
		chk("no std lv", drv_std_en[3:2], 2'h0);
		i2c_oe <= 4'h0; cyc(1); apb(1, FT, 32'h0000_3149); cyc(3);
		chk("lv buf start", i3c_in[3:2], 2'h0);
		chk("i3c buf sel", i3c_side_input_buffer_select, 6'h31);
		chk("sys buf sel", system_input_buffer_select, 6'h09);
		lv_buf_up <= 2'h2; cyc(3);
		chk("lv buf up", i3c_in[3:2], 2'h3);
	endtask

	task t_adc;
		adc_chan_sel <= `ADC_CH_BASE; cyc(3); chk("adc d2", vdiv_en, 2'h1);
		adc_chan_sel <= `ADC_CH_BASE + 6'h01; cyc(3); chk("adc d3", vdiv_en, 2'h2);
		adc_chan_sel <= 6'h3E; cyc(3); chk("adc none", vdiv_en, 2'h0);
	endtask

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		t_regs;
		t_supply;
		t_pads;
		t_low;
		t_adc;
		final_report;
	end
endmodule
